// ===== rtl/telem_defines.svh
// register offsets, field positions and reset values of the telemetry readback bank
// assumes: included by bare name from the package, the checker and the bench
`ifndef TELEM_DEFINES_SVH
`define TELEM_DEFINES_SVH

// register indexes; the byte address on the bus is four times the index
`define TLM_IDX_DC_BUS 12'h474
`define TLM_IDX_PHASE_A 12'h47A
`define TLM_IDX_PHASE_B 12'h47C
`define TLM_IDX_PHASE_C 12'h47E
`define TLM_IDX_SINE 12'h4B6
`define TLM_IDX_COSINE 12'h4B8
`define TLM_IDX_CUR_X 12'h4D2
`define TLM_IDX_CUR_Y 12'h4D4
`define TLM_IDX_CTRL 12'h500
`define TLM_IDX_FRESH 12'h502
`define TLM_IDX_COUNT 12'h504
`define TLM_IDX_FAULT 12'h506

// storage slots of the telemetry words
`define TLM_SLOT_DC_BUS 3'h0
`define TLM_SLOT_PHASE_A 3'h1
`define TLM_SLOT_PHASE_B 3'h2
`define TLM_SLOT_PHASE_C 3'h3
`define TLM_SLOT_SINE 3'h4
`define TLM_SLOT_COSINE 3'h5
`define TLM_SLOT_CUR_X 3'h6
`define TLM_SLOT_CUR_Y 3'h7
`define TLM_NUM_SLOTS 8

// fixed-point format and reset value of every telemetry word
`define TLM_FRAC_BITS 27
`define TLM_WORD_RESET 32'h0000_0000

// control register fields
`define TLM_CTRL_FREEZE_BIT 0
`define TLM_CTRL_CLEAR_BIT 1
// fresh register field
`define TLM_FRESH_FREEZE_BIT 8

`endif

// ===== rtl/telem_pkg.sv
// types shared by the telemetry readback bank
// assumes: telem_defines.svh is on the include path
package telem_pkg;
  `include "telem_defines.svh"

  typedef logic [2:0] slot_t;

  // bus transfer phases as seen by the slave
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} apb_state_e;

  // own register selected by the address map
  typedef enum logic [1:0] {OWN_CTRL, OWN_FRESH, OWN_COUNT, OWN_FAULT} own_reg_e;

  // all state of the bank top
  typedef struct packed {
    apb_state_e state;
    logic freeze;
    logic [`TLM_NUM_SLOTS-1:0] fresh;
    logic [15:0] upd_cnt;
    logic [15:0] drop_cnt;
    logic [7:0] ro_wr_cnt;
    logic [15:0] fault_addr;
    logic [31:0] prdata;
    logic slverr;
  } bank_s;
endpackage

// ===== rtl/telem_word_mem.sv
// small word store for the telemetry values, registered read data
// assumes: one write port from the control side, one read port from the bus slave
`timescale 1ns/10ps
module telem_word_mem
  import telem_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_data;
  } mem_s;

  mem_s st_q;
  mem_s st_d;

  // refuse shapes the address arithmetic cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
    $error("telem_word_mem needs DEPTH of at least 2");
  end

  // read returns the old word when both ports hit one entry in a cycle
  always_comb begin
    st_d = st_q;
    if (rd_en) begin
      st_d.rd_data = st_q.mem[rd_addr];
    end
    if (wr_en) begin
      st_d.mem[wr_addr] = wr_data;
    end
  end

  // every word wakes as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_data;
endmodule

// ===== rtl/telem_addr_map.sv
// byte address decoder of the telemetry bank
// assumes: 32-bit bus, one aligned word per register
`timescale 1ns/10ps
module telem_addr_map
  import telem_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // bus address
  input wire logic [ADDR_W-1:0] paddr,
  // decode result
  output logic hit_slot,
  output slot_t slot,
  output logic hit_own,
  output own_reg_e own_sel
);
  logic [ADDR_W-1:0] idx;

  // index space must reach the highest own register
  if (ADDR_W < 14) begin : g_bad_width
    $error("telem_addr_map needs ADDR_W of at least 14");
  end

  // misaligned byte addresses never hit, the index drops the two lane bits
  assign idx = ADDR_W'(paddr >> 2);

  always_comb begin
    hit_slot = paddr[1:0] == 2'h0;
    hit_own = paddr[1:0] == 2'h0;
    slot = `TLM_SLOT_DC_BUS;
    own_sel = OWN_CTRL;
    case (idx)
      ADDR_W'(`TLM_IDX_DC_BUS): slot = `TLM_SLOT_DC_BUS;
      ADDR_W'(`TLM_IDX_PHASE_A): slot = `TLM_SLOT_PHASE_A;
      ADDR_W'(`TLM_IDX_PHASE_B): slot = `TLM_SLOT_PHASE_B;
      ADDR_W'(`TLM_IDX_PHASE_C): slot = `TLM_SLOT_PHASE_C;
      ADDR_W'(`TLM_IDX_SINE): slot = `TLM_SLOT_SINE;
      ADDR_W'(`TLM_IDX_COSINE): slot = `TLM_SLOT_COSINE;
      ADDR_W'(`TLM_IDX_CUR_X): slot = `TLM_SLOT_CUR_X;
      ADDR_W'(`TLM_IDX_CUR_Y): slot = `TLM_SLOT_CUR_Y;
      default: hit_slot = 1'b0;
    endcase
    case (idx)
      ADDR_W'(`TLM_IDX_CTRL): own_sel = OWN_CTRL;
      ADDR_W'(`TLM_IDX_FRESH): own_sel = OWN_FRESH;
      ADDR_W'(`TLM_IDX_COUNT): own_sel = OWN_COUNT;
      ADDR_W'(`TLM_IDX_FAULT): own_sel = OWN_FAULT;
      default: hit_own = 1'b0;
    endcase
  end
endmodule

// ===== rtl/telem_readback.sv
// telemetry readback bank of the motor controller: fixed-point values written by the
// control algorithm, read by software over APB
// assumes: update port driven by logic on pclk, an APB master on the same clock
`timescale 1ns/10ps
module telem_readback
  import telem_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // telemetry updates from the control algorithm
  input wire logic upd_valid,
  input wire slot_t upd_slot,
  input wire logic [31:0] upd_data,
  // status toward the control side
  output logic frozen
);
  bank_s st_q;
  bank_s st_d;

  // decoder results
  logic hit_slot;
  slot_t slot;
  logic hit_own;
  own_reg_e own_sel;

  // memory ports
  logic mem_wr_en;
  logic mem_rd_en;
  logic [31:0] mem_rd_data;

  // bus phase qualifiers
  logic setup_phase;
  logic done_phase;
  logic wr_done;
  logic rd_done;
  logic clear_req;

  // own register images
  logic [31:0] ctrl_word;
  logic [31:0] fresh_word;
  logic [31:0] count_word;
  logic [31:0] fault_word;
  logic [31:0] own_word;

  // per-slot one-hot of update and read
  logic [`TLM_NUM_SLOTS-1:0] upd_hot;
  logic [`TLM_NUM_SLOTS-1:0] rd_hot;

  // address decode, purely combinational on the held bus address
  telem_addr_map #(
    .ADDR_W(ADDR_W)
  ) u_map (
    .paddr(paddr),
    .hit_slot(hit_slot),
    .slot(slot),
    .hit_own(hit_own),
    .own_sel(own_sel)
  );

  // phase decode; the master holds paddr and pwrite through the whole transfer
  assign setup_phase = psel && !penable && st_q.state == ST_IDLE;
  assign done_phase = psel && penable && st_q.state == ST_DONE;
  assign wr_done = done_phase && pwrite;
  assign rd_done = done_phase && !pwrite;

  // the store is written only by the control side, never by the bus
  assign mem_wr_en = upd_valid && !st_q.freeze;
  // the read is launched in the setup cycle so the word is ready one edge later
  assign mem_rd_en = setup_phase && hit_slot;

  // word store, eight entries of telemetry
  telem_word_mem #(
    .WIDTH(32),
    .DEPTH(`TLM_NUM_SLOTS)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_wr_en),
    .wr_addr(upd_slot),
    .wr_data(upd_data),
    .rd_en(mem_rd_en),
    .rd_addr(slot),
    .rd_data(mem_rd_data)
  );

  // one-hot views of the slot touched by the control side and by a finished read
  genvar g;
  generate
    for (g = 0; g < `TLM_NUM_SLOTS; g++) begin : g_slot
      assign upd_hot[g] = mem_wr_en && upd_slot == slot_t'(g);
      assign rd_hot[g] = rd_done && hit_slot && slot == slot_t'(g);
    end
  endgenerate

  // clear pulse for the counters, a write of one to the clear field; not stored
  assign clear_req = wr_done && hit_own && own_sel == OWN_CTRL && pstrb[0] &&
    pwdata[`TLM_CTRL_CLEAR_BIT];

  // control word reads back the freeze level only, clear always reads zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`TLM_CTRL_FREEZE_BIT] = st_q.freeze;
  end

  // fresh flags and the freeze level in one status word
  always_comb begin
    fresh_word = '0;
    fresh_word[`TLM_NUM_SLOTS-1:0] = st_q.fresh;
    fresh_word[`TLM_FRESH_FREEZE_BIT] = st_q.freeze;
  end

  // accepted updates low, dropped updates high
  assign count_word = {st_q.drop_cnt, st_q.upd_cnt};
  // last refused address low, count of writes aimed at read-only words above it
  assign fault_word = {8'h00, st_q.ro_wr_cnt, st_q.fault_addr};

  // read mux of the bank's own registers
  always_comb begin
    case (own_sel)
      OWN_CTRL: own_word = ctrl_word;
      OWN_FRESH: own_word = fresh_word;
      OWN_COUNT: own_word = count_word;
      OWN_FAULT: own_word = fault_word;
      default: own_word = '0;
    endcase
  end

  // next state of the whole bank
  always_comb begin
    st_d = st_q;

    // bus sequencer: one wait state so read data always leave a flip-flop
    case (st_q.state)
      ST_IDLE: begin
        if (setup_phase) begin
          st_d.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        st_d.state = ST_DONE;
        st_d.slverr = !(hit_slot || hit_own);
        // writes return zero data; unmapped reads too
        if (pwrite || !(hit_slot || hit_own)) begin
          st_d.prdata = '0;
        end else if (hit_slot) begin
          st_d.prdata = mem_rd_data;
        end else begin
          st_d.prdata = own_word;
        end
      end
      ST_DONE: begin
        // a master that drops psel mid-transfer still releases the sequencer
        st_d.state = ST_IDLE;
        st_d.slverr = 1'b0;
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase

    // only the freeze field is stored; it gates updates, not the motor loop
    if (wr_done && hit_own && own_sel == OWN_CTRL && pstrb[0]) begin
      st_d.freeze = pwdata[`TLM_CTRL_FREEZE_BIT];
    end

    // writes to telemetry or status words leave them untouched and are only counted
    if (wr_done && (hit_slot || (hit_own && own_sel != OWN_CTRL))) begin
      if (st_q.ro_wr_cnt != 8'hFF) begin
        st_d.ro_wr_cnt = st_q.ro_wr_cnt + 8'h01;
      end
    end

    // keep the low 16 bits of the refused address for software to inspect
    if (done_phase && !(hit_slot || hit_own)) begin
      // size cast keeps the narrowest legal bus width (14 bits) in range
      st_d.fault_addr = 16'(paddr);
    end

    // fresh flags: a finished read clears, a same-cycle update sets again
    st_d.fresh = (st_q.fresh & ~rd_hot) | upd_hot;

    // counters saturate so a slow poller never sees them wrap to a small value
    if (clear_req) begin
      st_d.upd_cnt = '0;
      st_d.drop_cnt = '0;
      st_d.ro_wr_cnt = '0;
    end else begin
      if (mem_wr_en && st_q.upd_cnt != 16'hFFFF) begin
        st_d.upd_cnt = st_q.upd_cnt + 16'h0001;
      end
      if (upd_valid && st_q.freeze && st_q.drop_cnt != 16'hFFFF) begin
        st_d.drop_cnt = st_q.drop_cnt + 16'h0001;
      end
    end
  end

  // one register stage for the whole bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // answer lines: ready only in the final access cycle
  assign pready = st_q.state == ST_DONE;
  assign prdata = st_q.prdata;
  assign pslverr = st_q.state == ST_DONE && st_q.slverr;
  assign frozen = st_q.freeze;
endmodule

// ===== dv/telem_readback_props.sv
// checker of the telemetry bank, sees only the top ports
// assumes: bound to telem_readback, one clock, async active-low reset
`timescale 1ns/10ps
`include "telem_defines.svh"
module telem_readback_props
  import telem_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // update port and status
  input wire logic upd_valid,
  input wire slot_t upd_slot,
  input wire logic [31:0] upd_data,
  input wire logic frozen
);
  localparam logic [11:0] IDX [8] = '{`TLM_IDX_DC_BUS, `TLM_IDX_PHASE_A, `TLM_IDX_PHASE_B,
    `TLM_IDX_PHASE_C, `TLM_IDX_SINE, `TLM_IDX_COSINE, `TLM_IDX_CUR_X, `TLM_IDX_CUR_Y};
  logic [31:0] shadow_q [8];
  logic [31:0] exp_q;
  logic hit;
  slot_t hit_slot;
  // decode telemetry words only; of the own registers only the control word is checked, in p_freeze
  always_comb begin
    hit = 1'b0;
    hit_slot = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (paddr == ADDR_W'({IDX[i], 2'b00})) begin
        hit = 1'b1;
        hit_slot = i[2:0];
      end
    end
  end
  // shadow copy; read data is taken at the end of setup, so capture there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) shadow_q[i] <= 32'h0;
      exp_q <= 32'h0;
    end else begin
      if (upd_valid && !frozen) shadow_q[upd_slot] <= upd_data;
      if (psel && !penable) exp_q <= shadow_q[hit_slot];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; !pready ##1 pready; endsequence
  property p_wait_state; s_setup |=> s_access; endproperty
  a_wait_state: assert property (p_wait_state) else $error("pready not two cycles after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");
  property p_tel_read; pready && !pwrite && hit |-> !pslverr && prdata == exp_q; endproperty
  a_tel_read: assert property (p_tel_read) else $error("telemetry read data wrong");
  property p_reset_zero; disable iff (1'b0) !presetn |-> prdata == 32'h0 && !pready && !frozen; endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero in reset");
  property p_ro_write; pready && pwrite && hit |-> !pslverr ##1 frozen == $past(frozen); endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to telemetry word had an effect");
  property p_write_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_write_zero: assert property (p_write_zero) else $error("prdata not zero on write");
  property p_misaligned; pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0; endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");
  property p_freeze;
    pready && pwrite && pstrb[0] && paddr == ADDR_W'({`TLM_IDX_CTRL, 2'b00}) |=> frozen == $past(pwdata[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze bit not taken");
endmodule
bind telem_readback telem_readback_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .upd_valid(upd_valid), .upd_slot(upd_slot),
  .upd_data(upd_data), .frozen(frozen));

// ===== dv/tb_top.sv
// self-checking bench of the telemetry bank
// assumes: bench acts as APB master and as the control-side writer
`timescale 1ns/10ps
`include "telem_defines.svh"
module tb_top
  import telem_pkg::*;
;
  localparam logic [11:0] IDX [8] = '{`TLM_IDX_DC_BUS, `TLM_IDX_PHASE_A, `TLM_IDX_PHASE_B,
    `TLM_IDX_PHASE_C, `TLM_IDX_SINE, `TLM_IDX_COSINE, `TLM_IDX_CUR_X, `TLM_IDX_CUR_Y};
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, upd_data = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, frozen, upd_valid = 1'b0;
  slot_t upd_slot = 3'h0;
  int num_errors = 0, compares = 0;
  telem_readback dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .upd_valid(upd_valid), .upd_slot(upd_slot), .upd_data(upd_data), .frozen(frozen));
  // 25 ns period
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [15:0] ba(int i);
    return {2'b00, IDX[i], 2'b00};
  endfunction
  // distinct value per slot, sign bit set on every slot
  function automatic logic [31:0] val(int i);
    return {i[3:0] ^ 4'h9, 28'h5A3C96F};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound, no fixed latency assumed
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic [31:0] err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    err = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    logic [31:0] rd, e;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ba(i), 32'h0, rd, e);
      chk(rd, 32'h0);
    end
    $display("test reset values done");
  endtask
  task automatic t_update;
    logic [31:0] rd, e;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      upd_valid <= 1'b1;
      upd_slot <= i[2:0];
      upd_data <= val(i);
      @(posedge pclk);
    end
    upd_valid <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ba(i), 32'h0, rd, e);
      chk(rd, val(i));
    end
    $display("test update readback done");
  endtask
  task automatic t_ro_write;
    logic [31:0] rd, e;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ba(i), ~val(i), rd, e);
      chk(e, 32'h0);
      apb(1'b0, ba(i), 32'h0, rd, e);
      chk(rd, val(i));
    end
    chk({31'h0, frozen}, 32'h0);
    $display("test read-only writes done");
  endtask
  // unmapped and misaligned reads are refused; zero data is checked on the unmapped read only
  task automatic t_unmapped;
    logic [31:0] rd, e;
    apb(1'b0, 16'h11D4, 32'h0, rd, e);
    chk(e, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 16'h11D2, 32'h0, rd, e);
    chk(e, 32'h1);
    $display("test unmapped done");
  endtask
  // while frozen an update is dropped and the old word stays readable
  task automatic t_freeze;
    logic [31:0] rd, e;
    apb(1'b1, 16'h1400, 32'h1, rd, e);
    @(posedge pclk);
    chk({31'h0, frozen}, 32'h1);
    upd_valid <= 1'b1;
    upd_slot <= 3'h7;
    upd_data <= 32'hFFFF_FFFF;
    @(posedge pclk);
    upd_valid <= 1'b0;
    apb(1'b0, ba(7), 32'h0, rd, e);
    chk(rd, val(7));
    apb(1'b1, 16'h1400, 32'h0, rd, e);
    @(posedge pclk);
    chk({31'h0, frozen}, 32'h0);
    $display("test freeze done");
  endtask
  // own status words: counts, refused address, fresh flags and the clear pulse
  task automatic t_status;
    logic [31:0] rd, e;
    apb(1'b0, 16'h1410, 32'h0, rd, e);
    chk(rd, 32'h0001_0008);
    apb(1'b0, 16'h1418, 32'h0, rd, e);
    chk(rd, 32'h0008_11D2);
    upd_valid <= 1'b1;
    upd_slot <= 3'h2;
    upd_data <= 32'h1234_5678;
    @(posedge pclk);
    upd_valid <= 1'b0;
    apb(1'b0, 16'h1408, 32'h0, rd, e);
    chk(rd, 32'h0000_0004);
    apb(1'b0, ba(2), 32'h0, rd, e);
    chk(rd, 32'h1234_5678);
    apb(1'b1, 16'h1400, 32'h2, rd, e);
    apb(1'b0, 16'h1410, 32'h0, rd, e);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 16'h1418, 32'h0, rd, e);
    chk(rd, 32'h0000_11D2);
    $display("test status words done");
  endtask
  // reset in mid-run clears every written word and the freeze level
  task automatic t_midreset;
    logic [31:0] rd, e;
    apb(1'b1, 16'h1400, 32'h1, rd, e);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, frozen}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ba(i), 32'h0, rd, e);
      chk(rd, 32'h0);
    end
    $display("test mid-run reset done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    // asserted at time zero so the asynchronous clear fires before the first edge
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_update();
    t_ro_write();
    t_unmapped();
    t_freeze();
    t_status();
    t_midreset();
    close_out();
  end
endmodule
